// file: verilog/clock_select_pkg.sv
package clock_select_pkg;

  // Register byte offsets on the APB
  localparam logic [7:0] ADDR_OSC_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OSC_TUNE   = 8'h04;
  localparam logic [7:0] ADDR_OSC_CTRL2  = 8'h08;
  localparam logic [7:0] ADDR_GATE_ONE   = 8'h0c;
  localparam logic [7:0] ADDR_NVM_UNLOCK = 8'h10;
  localparam logic [7:0] ADDR_STATUS     = 8'h14;

  // Field positions
  localparam int POSTSCALE_LSB   = 4;
  localparam int SRC_SEL_BIT     = 7;
  localparam int PLL_EN_BIT      = 6;
  localparam int MID_SEL_BIT     = 0;
  localparam int MID_STABLE_BIT  = 1;
  localparam int TIMING_UNIT_BIT = 6;
  localparam int RTC_BIT         = 5;
  localparam int TIMER_LSB       = 1;

  // Values after reset and fixed codes
  localparam logic [2:0] POSTSCALE_RESET = 3'h6;
  localparam logic [7:0] GATE_RESET      = 8'h00;
  localparam logic [7:0] GATE_IMPL_MASK  = 8'h7e;
  localparam logic [7:0] UNLOCK_FIRST    = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND   = 8'haa;

  // Divide counts of the postscaler and the last phase of the quarter clock
  localparam logic [9:0] HF_LOW_DIV  = 10'h200;
  localparam logic [9:0] MF_LOW_DIV  = 10'h010;
  localparam logic [1:0] QUARTER_DIV = 2'h3;

  typedef enum logic [3:0] {
    SRC_HF  = 4'b0001,
    SRC_MF  = 4'b0010,
    SRC_LF  = 4'b0100,
    SRC_PLL = 4'b1000
  } src_t;

  typedef enum logic [2:0] {
    LOCK_IDLE  = 3'b001,
    LOCK_HALF  = 3'b010,
    LOCK_ARMED = 3'b100
  } lock_t;

  typedef struct packed {
    src_t       src;
    logic [9:0] ratio;
  } clk_sel_t;

  // Source and divide ratio for a postscaler code
  function automatic clk_sel_t decode_select(input logic [2:0] code,
                                             input logic       low_src,
                                             input logic       mid_src,
                                             input logic       pll_ok);
    clk_sel_t s;
    s.src   = SRC_HF;
    s.ratio = 10'(1 << (3'h7 - code));
    if (pll_ok && code[2:1] == 2'h3) begin
      s.src   = SRC_PLL;
      s.ratio = 10'h001;
    end else if (code == 3'h0 && !low_src) begin
      s.src   = SRC_LF;
      s.ratio = 10'h001;
    end else if (code == 3'h0) begin
      s.src   = mid_src ? SRC_MF : SRC_HF;
      s.ratio = mid_src ? MF_LOW_DIV : HF_LOW_DIV;
    end else if (code[2:1] == 2'h0 || code == 3'h2) begin
      if (mid_src) begin
        s.src   = SRC_MF;
        s.ratio = 10'(1 << (3'h2 - code));
      end
    end
    return s;
  endfunction

endpackage

// file: verilog/tick_divider.sv
`timescale 1ns/1ps
module tick_divider (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Source ticks and ratio
  input  wire logic       src_tick,
  input  wire logic [9:0] ratio,
  input  wire logic       restart,
  // Divided tick
  output logic            out_tick
);
  logic [9:0] cnt;
  wire        last = (cnt == 10'(ratio - 10'h001));

  // Restart drops the old phase, so a fresh period is always whole
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt      <= 10'h000;
      out_tick <= 1'b0;
    end else begin
      out_tick <= src_tick && last;
      if (src_tick) cnt <= last ? 10'h000 : 10'(cnt + 10'h001);
    end
  end
endmodule // tick_divider

// file: verilog/quarter_clock.sv
`timescale 1ns/1ps
module quarter_clock (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // System tick in, quarter-rate level out
  input  wire logic sys_tick,
  output logic      quarter_level
);
  logic [1:0] phase;

  // Level is high for two system ticks and low for two
  always_ff @(posedge clk) begin
    if (rst) phase <= 2'h0;
    else if (sys_tick) phase <= (phase == clock_select_pkg::QUARTER_DIV) ? 2'h0 : 2'(phase + 2'h1);
  end

  assign quarter_level = phase[1];
endmodule // quarter_clock

// file: verilog/internal_osc_clock_select.sv
// Overview of operation
// [R1] PLL on internal block when primary, 64 MHz
// [R2] Software enables PLL only at codes 111/110
// [R3] Three-bit postscaler spans 31 kHz to 16 MHz
// [R4] Low range from HF when source=1, mid=0
// [R5] Low range from MF when source=1, mid=1
// [R6] Source bit 0: LF oscillator gives 31 kHz
// [R7] LF oscillator on when selected or features need
// [R8] Reset default selection is 8 MHz
// [R9] Source bit 7 tuning, mid bit 0 control two
// [R10] Pin mode comes from configuration, not registers
// [R11] Clock-out mode drives Fosc/4 on output pin
// [R12] Pure IO mode frees both oscillator pins
// [R13] Bit 6 stops timing-unit clocks
// [R14] Bit 5 stops real-time clock clocks
// [R15] Bit 5 set only right after unlock
// [R16] Bits 4..1 stop timers four to one
// [R17] Gate register bits 7 and 0 read zero
// [R18] Codes 111..011 give 16 MHz to 1 MHz
// [R19] HF low codes divide 32, 64, 512
// [R20] MF low codes divide 1, 2, 16
// [R21] Postscaler write switches frequency immediately
// [R22] Source switching never emits runt pulses
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module internal_osc_clock_select (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Oscillator ticks, one-cycle enables on CLOCK
  input  wire logic        HF_TICK,
  input  wire logic        MF_TICK,
  input  wire logic        LF_TICK,
  input  wire logic        PLL_TICK,
  input  wire logic        MF_STABLE_RAW,
  // Configuration and feature enables
  input  wire logic        CFG_INTERNAL_PRIMARY,
  input  wire logic        CFG_CLOCKOUT_MODE,
  input  wire logic        PWRT_EN,
  input  wire logic        FSCM_EN,
  input  wire logic        WDT_EN,
  input  wire logic        IESO_EN,
  // Clock enables out
  output logic             SYS_CLK_EN,
  output logic             TIMING_UNIT_CLK_EN,
  output logic             RTC_CLK_EN,
  output logic [3:0]       TIMER_CLK_EN,
  output logic             LF_OSC_ON,
  output logic             PLL_ON,
  // Port latches from the GPIO block
  input  wire logic        PORT_A_BIT_SIX_LAT,
  input  wire logic        PORT_A_BIT_SIX_DRIVE,
  input  wire logic        PORT_A_BIT_SEVEN_LAT,
  input  wire logic        PORT_A_BIT_SEVEN_DRIVE,
  output logic             PORT_A_BIT_SIX_VAL,
  output logic             PORT_A_BIT_SEVEN_VAL,
  // Oscillator pins, three signals each
  input  wire logic        OSC_PIN_OUT_RD,
  output logic             OSC_PIN_OUT_DRV,
  output logic             OSC_PIN_OUT_OE,
  input  wire logic        OSC_PIN_IN_RD,
  output logic             OSC_PIN_IN_DRV,
  output logic             OSC_PIN_IN_OE
);

  // Register state
  logic [2:0]                postscaler_select;
  logic                      low_range_source_select;
  logic                      pll_enable;
  logic                      mid_source_select;
  logic [7:0]                gate;
  clock_select_pkg::lock_t   lock_state;
  clock_select_pkg::lock_t   next_lock_state;
  clock_select_pkg::clk_sel_t sel_q;
  logic                      internal_primary;
  logic                      clockout_mode;
  logic                      mid_osc_stable_flag;
  logic [2:0]                stable_sync;
  logic [2:0]                a6_sync;
  logic [2:0]                a7_sync;
  logic                      sys_tick;
  logic                      quarter_level;

  // APB decode
  wire setup_phase = PSEL && !PENABLE;
  wire wr_access   = PSEL && PENABLE && PWRITE;
  wire hit_ctrl    = (PADDR == clock_select_pkg::ADDR_OSC_CTRL);
  wire hit_tune    = (PADDR == clock_select_pkg::ADDR_OSC_TUNE);
  wire hit_ctrl2   = (PADDR == clock_select_pkg::ADDR_OSC_CTRL2);
  wire hit_gate    = (PADDR == clock_select_pkg::ADDR_GATE_ONE);
  wire hit_unlock  = (PADDR == clock_select_pkg::ADDR_NVM_UNLOCK);
  wire hit_status  = (PADDR == clock_select_pkg::ADDR_STATUS);
  wire mapped      = hit_ctrl || hit_tune || hit_ctrl2 || hit_gate || hit_unlock || hit_status;
  wire [7:0] wbyte = PWDATA[7:0];

  // Zero-wait slave, every access ends in its first access cycle
  assign PREADY = 1'b1;

  // Selection of source and ratio
  wire pll_ok = pll_enable && internal_primary; // [R1]
  wire clock_select_pkg::clk_sel_t next_sel =
    clock_select_pkg::decode_select(postscaler_select, low_range_source_select,
                                    mid_source_select, pll_ok); // [R3] [R4] [R5] [R6] [R18]
  wire sel_change = (next_sel != sel_q);

  // Tick of the chosen source
  wire src_tick = (sel_q.src == clock_select_pkg::SRC_PLL) ? PLL_TICK :
                  (sel_q.src == clock_select_pkg::SRC_MF)  ? MF_TICK  :
                  (sel_q.src == clock_select_pkg::SRC_LF)  ? LF_TICK  : HF_TICK;

  // Gate-register write filtering
  wire rtc_allow  = (lock_state == clock_select_pkg::LOCK_ARMED);
  wire rtc_bit_wr = wbyte[clock_select_pkg::RTC_BIT] &&
                    (rtc_allow || gate[clock_select_pkg::RTC_BIT]); // [R15]
  wire [7:0] gate_wr = (wbyte & clock_select_pkg::GATE_IMPL_MASK &
                        ~(8'h01 << clock_select_pkg::RTC_BIT)) |
                       8'({7'h00, rtc_bit_wr} << clock_select_pkg::RTC_BIT); // [R17]

  // Read multiplexer, bits not shown read zero
  wire [7:0] rd_byte =
    hit_ctrl   ? 8'({postscaler_select} << clock_select_pkg::POSTSCALE_LSB) :
    hit_tune   ? 8'({low_range_source_select, pll_enable} << clock_select_pkg::PLL_EN_BIT) :
    hit_ctrl2  ? 8'({mid_osc_stable_flag, mid_source_select} << clock_select_pkg::MID_SEL_BIT) :
    hit_gate   ? (gate & clock_select_pkg::GATE_IMPL_MASK) : // [R17]
    hit_status ? {2'h0, LF_OSC_ON, PLL_ON, sel_q.src} : 8'h00;

  // Configuration captured while reset holds, stable afterwards
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      internal_primary <= CFG_INTERNAL_PRIMARY;
      clockout_mode    <= CFG_CLOCKOUT_MODE; // [R10]
    end
  end

  // Oscillator control fields
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      postscaler_select       <= clock_select_pkg::POSTSCALE_RESET; // [R8]
      low_range_source_select <= 1'b0;
      pll_enable              <= 1'b0;
      mid_source_select       <= 1'b0;
    end else if (wr_access) begin
      if (hit_ctrl)
        postscaler_select <= wbyte[clock_select_pkg::POSTSCALE_LSB +: 3]; // [R21]
      if (hit_tune) begin
        low_range_source_select <= wbyte[clock_select_pkg::SRC_SEL_BIT]; // [R9]
        pll_enable              <= wbyte[clock_select_pkg::PLL_EN_BIT]; // [R1]
      end
      if (hit_ctrl2)
        mid_source_select <= wbyte[clock_select_pkg::MID_SEL_BIT]; // [R9]
    end
  end

  // Peripheral gate register
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) gate <= clock_select_pkg::GATE_RESET;
    else if (wr_access && hit_gate) gate <= gate_wr; // [R15]
  end

  // Unlock sequence; the armed state lasts one following write
  always_comb begin
    next_lock_state = lock_state;
    if (wr_access) begin
      case (lock_state)
        clock_select_pkg::LOCK_IDLE:
          if (hit_unlock && wbyte == clock_select_pkg::UNLOCK_FIRST)
            next_lock_state = clock_select_pkg::LOCK_HALF;
        clock_select_pkg::LOCK_HALF:
          if (hit_unlock && wbyte == clock_select_pkg::UNLOCK_SECOND)
            next_lock_state = clock_select_pkg::LOCK_ARMED;
          else
            next_lock_state = clock_select_pkg::LOCK_IDLE;
        default:
          next_lock_state = clock_select_pkg::LOCK_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) lock_state <= clock_select_pkg::LOCK_IDLE;
    else lock_state <= next_lock_state;
  end

  // Read data and error registered in setup so they stand through access
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup_phase) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      PSLVERR <= !mapped;
    end
  end

  // Selection applies at once; the divider restarts on the change
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) sel_q <= clock_select_pkg::decode_select(
                   clock_select_pkg::POSTSCALE_RESET, 1'b0, 1'b0, 1'b0);
    else sel_q <= next_sel; // [R21]
  end

  // Postscaler divider over the chosen source
  tick_divider u_postscaler (
    .clk      (CLOCK),
    .rst      (SYS_RST),
    .src_tick (src_tick),
    .ratio    (sel_q.ratio),
    .restart  (sel_change),
    .out_tick (sys_tick)
  ); // [R19] [R20] [R22]

  // Instruction-rate level for the clock-out pin
  quarter_clock u_quarter (
    .clk           (CLOCK),
    .rst           (SYS_RST),
    .sys_tick      (sys_tick),
    .quarter_level (quarter_level)
  );

  // Three-flop synchronisers; a change counts when stages two and three agree
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      stable_sync <= 3'h0;
      a6_sync     <= 3'h0;
      a7_sync     <= 3'h0;
    end else begin
      stable_sync <= {stable_sync[1:0], MF_STABLE_RAW};
      a6_sync     <= {a6_sync[1:0], OSC_PIN_OUT_RD};
      a7_sync     <= {a7_sync[1:0], OSC_PIN_IN_RD};
    end
  end

  // Clock enables and oscillator controls, one cycle behind the divider
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      SYS_CLK_EN         <= 1'b0;
      TIMING_UNIT_CLK_EN <= 1'b0;
      RTC_CLK_EN         <= 1'b0;
      TIMER_CLK_EN       <= 4'h0;
      LF_OSC_ON          <= 1'b1;
      PLL_ON             <= 1'b0;
    end else begin
      SYS_CLK_EN         <= sys_tick;
      TIMING_UNIT_CLK_EN <= sys_tick && !gate[clock_select_pkg::TIMING_UNIT_BIT]; // [R13]
      RTC_CLK_EN         <= sys_tick && !gate[clock_select_pkg::RTC_BIT]; // [R14]
      TIMER_CLK_EN       <= {4{sys_tick}} & ~gate[clock_select_pkg::TIMER_LSB +: 4]; // [R16]
      LF_OSC_ON          <= (sel_q.src == clock_select_pkg::SRC_LF) ||
                            PWRT_EN || FSCM_EN || WDT_EN || IESO_EN; // [R7]
      PLL_ON             <= (sel_q.src == clock_select_pkg::SRC_PLL); // [R1]
    end
  end

  // Pins: clock-out mode drives the output pin, else both are port bits
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      OSC_PIN_OUT_DRV      <= 1'b0;
      OSC_PIN_OUT_OE       <= 1'b0;
      OSC_PIN_IN_DRV       <= 1'b0;
      OSC_PIN_IN_OE        <= 1'b0;
      PORT_A_BIT_SIX_VAL   <= 1'b0;
      PORT_A_BIT_SEVEN_VAL <= 1'b0;
      mid_osc_stable_flag  <= 1'b0;
    end else begin
      OSC_PIN_OUT_DRV      <= clockout_mode ? quarter_level : PORT_A_BIT_SIX_LAT; // [R11]
      OSC_PIN_OUT_OE       <= clockout_mode || PORT_A_BIT_SIX_DRIVE; // [R12]
      OSC_PIN_IN_DRV       <= PORT_A_BIT_SEVEN_LAT; // [R11] [R12]
      OSC_PIN_IN_OE        <= PORT_A_BIT_SEVEN_DRIVE;
      if (a6_sync[2] == a6_sync[1]) PORT_A_BIT_SIX_VAL <= a6_sync[2];
      if (a7_sync[2] == a7_sync[1]) PORT_A_BIT_SEVEN_VAL <= a7_sync[2];
      if (stable_sync[2] == stable_sync[1]) mid_osc_stable_flag <= stable_sync[2];
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_unlocked;
    lock_state == clock_select_pkg::LOCK_ARMED;
  endsequence

  sequence s_rtc_set_write;
    wr_access && hit_gate && wbyte[clock_select_pkg::RTC_BIT];
  endsequence

  a_rtc_locked: assert property ( // [R15]
    (s_rtc_set_write and !rtc_allow and !gate[clock_select_pkg::RTC_BIT]) |=>
      !gate[clock_select_pkg::RTC_BIT])
    else $error("real-time clock disable set without unlock");

  a_rtc_unlocked: assert property ( // [R15]
    (s_unlocked and s_rtc_set_write) |=> gate[clock_select_pkg::RTC_BIT] ##1 !rtc_allow)
    else $error("real-time clock disable not accepted after unlock");

  a_gate_reserved: assert property ( // [R17]
    (setup_phase && !PWRITE && hit_gate) |=> PRDATA[7] == 1'b0 && PRDATA[0] == 1'b0)
    else $error("reserved gate bits read non-zero");

  a_lf_feature_on: assert property ( // [R7]
    (PWRT_EN || FSCM_EN || WDT_EN || IESO_EN) |=> LF_OSC_ON)
    else $error("low-frequency oscillator off while a feature needs it");

  a_pll_only_high: assert property ( // [R1]
    PLL_ON |-> $past(pll_ok, 2) && $past(postscaler_select[2:1], 2) == 2'h3)
    else $error("PLL selected without enable or at a low code");

  a_switch_now: assert property ( // [R21]
    (wr_access && hit_ctrl && wbyte[6:4] != postscaler_select) |=>
      ##1 sel_q == $past(next_sel))
    else $error("postscaler write did not switch the selection");

  a_timer_gated: assert property ( // [R16]
    gate[clock_select_pkg::TIMER_LSB] [*2] |-> !TIMER_CLK_EN[0])
    else $error("timer one clock passed while disabled");

  // A one-to-one ratio may tick two cycles after a switch, so only longer ratios are held off
  a_no_runt: assert property ( // [R22]
    (sel_change ##1 (sel_q.ratio != 10'h001)) |-> !sys_tick [*2])
    else $error("clock tick right after a source switch");

  a_pin_release: assert property ( // [R12]
    !clockout_mode |=> OSC_PIN_OUT_OE == $past(PORT_A_BIT_SIX_DRIVE))
    else $error("output pin not released in pure IO mode");

  a_reset_code: assert property ( // [R8]
    $fell(SYS_RST) |-> postscaler_select == clock_select_pkg::POSTSCALE_RESET)
    else $error("postscaler not at 8 MHz code after reset");

  // The PLL stays out of use unless the internal block is the primary clock
  a_pll_primary: assert property ( // [R1]
    !internal_primary |-> !PLL_ON)
    else $error("PLL in use while the internal block is not primary");

  // Running from the low-frequency oscillator keeps it powered
  a_lf_selected: assert property ( // [R7]
    (sel_q.src == clock_select_pkg::SRC_LF) |=> LF_OSC_ON)
    else $error("low-frequency oscillator off while selected");

endmodule // internal_osc_clock_select

// file: testbench/tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  // Clock, reset and bus
  logic        CLOCK = 1'b0, SYS_RST = 1'b1;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic        PREADY, PSLVERR;
  // Ticks, configuration, feature enables and pins
  logic        HF_TICK = 1'b1, MF_TICK = 1'b1, LF_TICK = 1'b1, PLL_TICK = 1'b1;
  logic        CFG_CLOCKOUT_MODE = 1'b1, CFG_INTERNAL_PRIMARY = 1'b1;
  logic [3:0]  feat = 4'h0;
  logic        six_lat = 1'b0, six_drv = 1'b0, sev_lat = 1'b0, sev_drv = 1'b0;
  logic        OUT_RD = 1'b0, IN_RD = 1'b0;
  logic        SYS_CLK_EN, TIMING_UNIT_CLK_EN, RTC_CLK_EN, LF_OSC_ON, PLL_ON;
  logic [3:0]  TIMER_CLK_EN;
  logic        SIX_VAL, SEVEN_VAL, OUT_DRV, OUT_OE, IN_DRV, IN_OE;
  logic [31:0] rd;
  logic        err;
  int          failures = 0, compares = 0;

  internal_osc_clock_select DUT (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .HF_TICK(HF_TICK), .MF_TICK(MF_TICK), .LF_TICK(LF_TICK), .PLL_TICK(PLL_TICK),
    .MF_STABLE_RAW(1'b1), .CFG_INTERNAL_PRIMARY(CFG_INTERNAL_PRIMARY),
    .CFG_CLOCKOUT_MODE(CFG_CLOCKOUT_MODE),
    .PWRT_EN(feat[0]), .FSCM_EN(feat[1]), .WDT_EN(feat[2]), .IESO_EN(feat[3]),
    .SYS_CLK_EN(SYS_CLK_EN), .TIMING_UNIT_CLK_EN(TIMING_UNIT_CLK_EN), .RTC_CLK_EN(RTC_CLK_EN),
    .TIMER_CLK_EN(TIMER_CLK_EN), .LF_OSC_ON(LF_OSC_ON), .PLL_ON(PLL_ON),
    .PORT_A_BIT_SIX_LAT(six_lat), .PORT_A_BIT_SIX_DRIVE(six_drv),
    .PORT_A_BIT_SEVEN_LAT(sev_lat), .PORT_A_BIT_SEVEN_DRIVE(sev_drv),
    .PORT_A_BIT_SIX_VAL(SIX_VAL), .PORT_A_BIT_SEVEN_VAL(SEVEN_VAL),
    .OSC_PIN_OUT_RD(OUT_RD), .OSC_PIN_OUT_DRV(OUT_DRV), .OSC_PIN_OUT_OE(OUT_OE),
    .OSC_PIN_IN_RD(IN_RD), .OSC_PIN_IN_DRV(IN_DRV), .OSC_PIN_IN_OE(IN_OE)
  );

  // 50 MHz clock
  initial begin
    forever #10 CLOCK = ~CLOCK;
  end

  task automatic results();
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog sized well above the longest expected run
  initial begin
    #400000; // About 20,000 cycles, several times the whole run
    failures++;
    results();
  end

  task automatic do_reset();
    @(posedge CLOCK);
    SYS_RST <= 1'b1;
    repeat (3) @(posedge CLOCK);
    SYS_RST <= 1'b0;
  endtask

  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
  endtask

  // Wait for a system tick, sampled on the falling edge so values are settled
  task automatic wait_tick();
    int n;
    n = 0;
    @(negedge CLOCK);
    while (SYS_CLK_EN !== 1'b1 && n < 2000) begin
      @(negedge CLOCK);
      n++;
    end
  endtask

  // Spacing of steady system ticks; three cycles let stale pulses of the old ratio pass
  task automatic period(output int p);
    repeat (3) @(negedge CLOCK);
    wait_tick();
    p = 1;
    @(negedge CLOCK);
    while (SYS_CLK_EN !== 1'b1 && p < 2000) begin
      @(negedge CLOCK);
      p++;
    end
  endtask

  task automatic t_reset_values();
    apb(1'b0, clock_select_pkg::ADDR_GATE_ONE, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, clock_select_pkg::ADDR_OSC_CTRL, 32'h0);
    `CHK(rd[6:4], 3'h6)
    apb(1'b0, clock_select_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[3:0], 4'(clock_select_pkg::SRC_HF))
    apb(1'b0, clock_select_pkg::ADDR_OSC_CTRL2, 32'h0);
    `CHK(rd[1:0], 2'h2)
    apb(1'b0, 8'h18, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask

  // Every postscaler code from HF, the three low codes from MF and code 000 from LF
  task automatic t_ratios();
    logic [2:0] code [12] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0,
                              3'h2, 3'h1, 3'h0, 3'h0};
    logic       srcb [12] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 1, 0};
    logic       mid  [12] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 0};
    int         rat  [12] = '{1, 2, 4, 8, 16, 32, 64, 512, 1, 2, 16, 1};
    logic [3:0] esrc [12];
    int         p;
    for (int i = 0; i < 12; i++) begin
      esrc[i] = (i < 8) ? 4'h1 : (i < 11) ? 4'h2 : 4'h4;
      apb(1'b1, clock_select_pkg::ADDR_OSC_TUNE, {24'h0, srcb[i], 7'h0});
      apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL2, {31'h0, mid[i]});
      apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL, {25'h0, code[i], 4'h0});
      period(p);
      `CHK(p, rat[i])
      apb(1'b0, clock_select_pkg::ADDR_STATUS, 32'h0);
      `CHK(rd[3:0], esrc[i])
    end
  endtask

  task automatic gate_check(input logic tu, input logic rt, input logic [3:0] tm);
    wait_tick();
    `CHK({TIMING_UNIT_CLK_EN, RTC_CLK_EN, TIMER_CLK_EN}, {tu, rt, tm})
  endtask

  task automatic t_gates();
    apb(1'b1, clock_select_pkg::ADDR_OSC_TUNE, 32'h80);
    apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL, 32'h70);
    gate_check(1'b1, 1'b1, 4'hf);
    apb(1'b1, clock_select_pkg::ADDR_GATE_ONE, 32'hff);
    apb(1'b0, clock_select_pkg::ADDR_GATE_ONE, 32'h0);
    `CHK(rd, 32'h5e)
    gate_check(1'b0, 1'b1, 4'h0);
    apb(1'b1, clock_select_pkg::ADDR_GATE_ONE, 32'h0);
    apb(1'b1, clock_select_pkg::ADDR_NVM_UNLOCK, 32'h55);
    apb(1'b1, clock_select_pkg::ADDR_NVM_UNLOCK, 32'haa);
    apb(1'b1, clock_select_pkg::ADDR_GATE_ONE, 32'h20);
    apb(1'b0, clock_select_pkg::ADDR_GATE_ONE, 32'h0);
    `CHK(rd, 32'h20)
    gate_check(1'b1, 1'b0, 4'hf);
    apb(1'b1, clock_select_pkg::ADDR_GATE_ONE, 32'h0);
    apb(1'b0, clock_select_pkg::ADDR_GATE_ONE, 32'h0);
    `CHK(rd, 32'h0)
  endtask

  task automatic t_pll();
    int p;
    apb(1'b1, clock_select_pkg::ADDR_OSC_TUNE, 32'hc0);
    apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL, 32'h70);
    period(p);
    `CHK({PLL_ON, 10'(p)}, {1'b1, 10'h001})
    apb(1'b0, clock_select_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[4:0], {1'b1, 4'(clock_select_pkg::SRC_PLL)})
    apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL, 32'h50);
    period(p);
    `CHK({PLL_ON, 10'(p)}, {1'b0, 10'h004})
    apb(1'b1, clock_select_pkg::ADDR_OSC_TUNE, 32'h80);
  endtask

  task automatic t_low_osc();
    apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL, 32'h70);
    repeat (3) @(negedge CLOCK);
    `CHK(LF_OSC_ON, 1'b0)
    for (int i = 0; i < 4; i++) begin
      @(posedge CLOCK);
      feat <= 4'(1 << i);
      repeat (3) @(negedge CLOCK);
      `CHK(LF_OSC_ON, 1'b1)
      @(posedge CLOCK);
      feat <= 4'h0;
      repeat (3) @(negedge CLOCK);
    end
    apb(1'b1, clock_select_pkg::ADDR_OSC_TUNE, 32'h0);
    apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL, 32'h0);
    repeat (3) @(negedge CLOCK);
    `CHK(LF_OSC_ON, 1'b1)
    apb(1'b1, clock_select_pkg::ADDR_OSC_TUNE, 32'h80);
    apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL, 32'h70);
  endtask

  // One system tick per cycle: the clock-out level must flip every second cycle
  task automatic t_clockout();
    logic prev;
    int   flips;
    flips = 0;
    sev_lat <= 1'b1; sev_drv <= 1'b1; IN_RD <= 1'b1;
    repeat (8) @(negedge CLOCK);
    prev = OUT_DRV;
    for (int i = 0; i < 8; i++) begin
      @(negedge CLOCK);
      if (OUT_DRV !== prev) flips++;
      prev = OUT_DRV;
    end
    `CHK({OUT_OE, 4'(flips)}, {1'b1, 4'h4})
    `CHK({IN_OE, IN_DRV, SEVEN_VAL}, 3'h7)
    @(posedge CLOCK);
    sev_lat <= 1'b0; sev_drv <= 1'b0; IN_RD <= 1'b0;
  endtask

  // Pure IO: both pins are driven from the port latches, and the output pin also reads back
  task automatic t_pure_io();
    six_lat <= 1'b1; six_drv <= 1'b1; OUT_RD <= 1'b1; sev_drv <= 1'b1;
    repeat (8) @(negedge CLOCK);
    `CHK({OUT_OE, OUT_DRV, SIX_VAL, IN_OE, IN_DRV}, 5'h1e)
    @(posedge CLOCK);
    six_lat <= 1'b0; six_drv <= 1'b0; OUT_RD <= 1'b0;
    repeat (8) @(negedge CLOCK);
    `CHK({OUT_OE, OUT_DRV, SIX_VAL}, 3'h0)
  endtask

  // Internal block not primary: the PLL enable must be refused
  task automatic t_pll_off();
    int p;
    apb(1'b1, clock_select_pkg::ADDR_OSC_TUNE, 32'hc0);
    apb(1'b1, clock_select_pkg::ADDR_OSC_CTRL, 32'h70);
    period(p);
    `CHK({PLL_ON, 10'(p)}, {1'b0, 10'h001})
    apb(1'b0, clock_select_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[4:0], {1'b0, 4'(clock_select_pkg::SRC_HF)})
  endtask

  initial begin
    do_reset();
    t_reset_values();
    t_ratios();
    t_gates();
    t_pll();
    t_low_osc();
    t_clockout();
    CFG_CLOCKOUT_MODE <= 1'b0;
    CFG_INTERNAL_PRIMARY <= 1'b0;
    do_reset();
    t_reset_values();
    t_pure_io();
    t_pll_off();
    results();
  end
endmodule // tb
